/* File: src/sst_pkg.sv */
package sst_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ     = 100;
  localparam int POWERUP_MS  = 15;
  localparam int SCL_LOW_MS  = 30;
  localparam int BUS_IDLE_US = 200;
  localparam int SCL_KHZ     = 400;
  localparam int CNT_W       = 22;

  localparam logic [CNT_W-1:0] POWERUP_CYC  = CNT_W'(POWERUP_MS * 1000 * CLK_MHZ);
  localparam logic [CNT_W-1:0] SCL_LOW_CYC  = CNT_W'(SCL_LOW_MS * 1000 * CLK_MHZ);
  localparam logic [CNT_W-1:0] BUS_IDLE_CYC = CNT_W'(BUS_IDLE_US * CLK_MHZ);
  // Quarter of an SCL period, rounded up so the rate never exceeds 400 kHz
  localparam int QTR_CYC = (CLK_MHZ * 1000 + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ);
  localparam logic [7:0] SCL_QTR_LAST = 8'(QTR_CYC - 1);
  localparam logic [3:0] STRAP_SETTLE_CYC = 4'h8;

  // ****************************************
  // Strap codes and bus addresses
  // ****************************************
  localparam logic [2:0] STRAP_GND  = 3'h0;
  localparam logic [2:0] STRAP_56K  = 3'h1;
  localparam logic [2:0] STRAP_68K  = 3'h2;
  localparam logic [2:0] STRAP_82K  = 3'h3;
  localparam logic [2:0] STRAP_100K = 3'h4;
  localparam logic [2:0] STRAP_120K = 3'h5;
  localparam logic [2:0] STRAP_150K = 3'h6;
  localparam logic [2:0] STRAP_VDD  = 3'h7;

  localparam logic [6:0] ADDR_82K  = 7'h2c;
  localparam logic [6:0] ADDR_100K = 7'h2b;
  localparam logic [6:0] ADDR_120K = 7'h2a;
  localparam logic [6:0] ADDR_150K = 7'h29;
  localparam logic [6:0] ADDR_VDD  = 7'h28;
  localparam logic [6:0] ADDR_NONE = 7'h00;

  typedef enum logic [1:0] {PROTO_SPI4, PROTO_SPI3, PROTO_RSVD, PROTO_I2C} sst_proto_t;
  typedef enum logic [1:0] {
    CMD_WRITE_BYTE, CMD_READ_BYTE, CMD_SEND_BYTE, CMD_RECV_BYTE
  } sst_cmd_t;

  // ****************************************
  // Framing and reset values
  // ****************************************
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [1:0] RST_LINES  = 2'h3;
  localparam logic [2:0] RST_STRAP  = 3'h0;
  localparam logic [7:0] RST_PTR    = 8'h00;
  localparam logic [7:0] LEN_ONE    = 8'h01;

endpackage : sst_pkg

/* File: src/sst_bus_if.sv */
`timescale 1ns/10ps
interface sst_bus_if;
  logic host_clock_o;
  logic host_clock_oe_n;
  logic host_data_o;
  logic host_data_oe_n;
  logic dev_data_o;
  logic dev_data_oe_n;
  logic serial_select_n;
  logic two_wire_clock_pin;
  logic two_wire_data_pin;

  // Open drain with pull-ups: any enabled low driver wins
  assign two_wire_clock_pin = ~(~host_clock_oe_n & ~host_clock_o);
  assign two_wire_data_pin  = ~((~host_data_oe_n & ~host_data_o) | (~dev_data_oe_n & ~dev_data_o));

  modport dev (
    input  two_wire_clock_pin,
    input  two_wire_data_pin,
    input  serial_select_n,
    output dev_data_o,
    output dev_data_oe_n
  );

  modport host (
    input  two_wire_clock_pin,
    input  two_wire_data_pin,
    output host_clock_o,
    output host_clock_oe_n,
    output host_data_o,
    output host_data_oe_n,
    output serial_select_n
  );
endinterface : sst_bus_if

/* File: src/sst_line_sync.sv */
`timescale 1ns/10ps
module sst_line_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] lvl,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  // ****************************************
  // Two-flop synchroniser, edges from stage two only
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_q;
      logic sync_q;
      logic last_q;
      always_ff @(posedge clk) begin
        if (rst) begin
          meta_q <= RST_VAL[i];
          sync_q <= RST_VAL[i];
          last_q <= RST_VAL[i];
        end else begin
          meta_q <= raw[i];
          sync_q <= meta_q;
          last_q <= sync_q;
        end
      end
      assign lvl[i]  = sync_q;
      assign rise[i] = sync_q & ~last_q;
      assign fall[i] = ~sync_q & last_q;
    end
  endgenerate

endmodule : sst_line_sync

/* File: src/sst_slave.sv */
// Contract
// - Strap picks protocol and seven-bit address
// - GND four-wire, 56k three-wire, 68k reserved
// - Byte transactions plus headerless block transfers
// - Serial select pin ignored, tied low
// - Host traffic ignored for 15 ms
// - Tolerate stretching, never drive clock low
// - Start is data fall, clock high
// - Stop resets slave, ready for more
// - First byte: address then direction bit
// - Eight bits per byte, MSB first
// - Acknowledge received bytes in ninth clock
// - Master acks reads except the last
// - Clock low 30 ms resets, when enabled
// - Both high 200 us resets, when enabled
// - Write byte: address, index, data, stop
// - Read byte: index, repeated start, read
// - Index-only write just loads the pointer
// - Index-only write void in deepest sleep
// - Address-read returns byte at pointer
// - Block pointer advances, wraps FFh to 00h
`timescale 1ns/10ps
module sst_slave #(
  parameter logic [sst_pkg::CNT_W-1:0] POWERUP_CYC  = sst_pkg::POWERUP_CYC,
  parameter logic [sst_pkg::CNT_W-1:0] SCL_LOW_CYC  = sst_pkg::SCL_LOW_CYC,
  parameter logic [sst_pkg::CNT_W-1:0] BUS_IDLE_CYC = sst_pkg::BUS_IDLE_CYC
) (
  input  wire logic          CLK,
  input  wire logic          SYS_RST,
  sst_bus_if.dev             BUS,
  input  wire logic [2:0]    COMM_SELECT_STRAP,
  input  wire logic          DEEPEST_LOW_POWER_FLAG,
  input  wire logic          TIMEOUT_EN,
  output sst_pkg::sst_proto_t PROTOCOL,
  output logic      [6:0]    BUS_ADDR,
  output logic               BUS_READY,
  output logic      [7:0]    REG_PTR,
  output logic      [7:0]    REG_WADDR,
  output logic      [7:0]    REG_WDATA,
  output logic               REG_WR,
  input  wire logic [7:0]    REG_RDATA,
  output logic               REG_RD
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_RX, ST_RACK, ST_TX, ST_TACK, ST_SKIP
  } sst_state_t;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] line_lvl;
  logic [1:0] line_rise;
  logic [1:0] line_fall;
  logic [2:0] strap_lvl;

  sst_line_sync #(.W(2), .RST_VAL(sst_pkg::RST_LINES)) u_lines (
    .clk  (CLK),
    .rst  (SYS_RST),
    .raw  ({BUS.two_wire_clock_pin, BUS.two_wire_data_pin}),
    .lvl  (line_lvl),
    .rise (line_rise),
    .fall (line_fall)
  );

  sst_line_sync #(.W(3), .RST_VAL(sst_pkg::RST_STRAP)) u_strap (
    .clk  (CLK),
    .rst  (SYS_RST),
    .raw  (COMM_SELECT_STRAP),
    .lvl  (strap_lvl),
    .rise (),
    .fall ()
  );

  // Clock is only ever sampled, so stretching by the master is harmless
  wire scl      = line_lvl[1];
  wire sda      = line_lvl[0];
  wire scl_rise = line_rise[1];
  wire scl_fall = line_fall[1];
  wire start_ev = line_fall[0] & scl;
  wire stop_ev  = line_rise[0] & scl;

  // ****************************************
  // Strap decode and capture
  // ****************************************
  wire sst_pkg::sst_proto_t strap_proto =
      (strap_lvl == sst_pkg::STRAP_GND) ? sst_pkg::PROTO_SPI4 :
      (strap_lvl == sst_pkg::STRAP_56K) ? sst_pkg::PROTO_SPI3 :
      (strap_lvl == sst_pkg::STRAP_68K) ? sst_pkg::PROTO_RSVD :
                                          sst_pkg::PROTO_I2C;
  wire [6:0] strap_addr =
      (strap_lvl == sst_pkg::STRAP_82K)  ? sst_pkg::ADDR_82K  :
      (strap_lvl == sst_pkg::STRAP_100K) ? sst_pkg::ADDR_100K :
      (strap_lvl == sst_pkg::STRAP_120K) ? sst_pkg::ADDR_120K :
      (strap_lvl == sst_pkg::STRAP_150K) ? sst_pkg::ADDR_150K :
      (strap_lvl == sst_pkg::STRAP_VDD)  ? sst_pkg::ADDR_VDD  :
                                           sst_pkg::ADDR_NONE;

  logic [3:0]               settle_q;
  logic                     strap_done_q;
  sst_pkg::sst_proto_t      proto_q;
  logic [6:0]               addr_q;
  logic [sst_pkg::CNT_W-1:0] up_cnt_q;
  logic                     ready_q;

  // Strap is caught once, after the synchroniser has settled
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      settle_q     <= 4'h0;
      strap_done_q <= 1'b0;
      proto_q      <= sst_pkg::PROTO_RSVD;
      addr_q       <= sst_pkg::ADDR_NONE;
    end else if (!strap_done_q) begin
      settle_q <= settle_q + 4'h1;
      if (settle_q == sst_pkg::STRAP_SETTLE_CYC) begin
        strap_done_q <= 1'b1;
        proto_q      <= strap_proto;
        addr_q       <= strap_addr;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      up_cnt_q <= '0;
      ready_q  <= 1'b0;
    end else if (up_cnt_q != POWERUP_CYC) begin
      up_cnt_q <= up_cnt_q + 1'b1;
    end else begin
      ready_q  <= 1'b1;
    end
  end

  // Serial select is deliberately not consulted in two-wire mode
  wire active = ready_q & strap_done_q & (proto_q == sst_pkg::PROTO_I2C);

  // ****************************************
  // Timeouts
  // ****************************************
  logic [sst_pkg::CNT_W-1:0] low_cnt_q;
  logic [sst_pkg::CNT_W-1:0] idle_cnt_q;

  always_ff @(posedge CLK) begin
    if (SYS_RST || scl) begin
      low_cnt_q <= '0;
    end else if (low_cnt_q != SCL_LOW_CYC) begin
      low_cnt_q <= low_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST || !(scl && sda)) begin
      idle_cnt_q <= '0;
    end else if (idle_cnt_q != BUS_IDLE_CYC) begin
      idle_cnt_q <= idle_cnt_q + 1'b1;
    end
  end

  wire tmo_low  = TIMEOUT_EN & (low_cnt_q == SCL_LOW_CYC);
  // Gated by live idle levels, else a start after long idle is swallowed
  wire tmo_idle = TIMEOUT_EN & (idle_cnt_q == BUS_IDLE_CYC) & scl & sda;

  // ****************************************
  // Protocol engine
  // ****************************************
  sst_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] idx_q, idx_d;
  logic [7:0] ptr_q, ptr_d;
  logic [7:0] waddr_q, waddr_d;
  logic [7:0] wdat_q, wdat_d;
  logic       rw_q, rw_d;
  logic       first_q, first_d;
  logic       pend_q, pend_d;
  logic       ack_q, ack_d;
  logic       oe_n_q, oe_n_d;
  logic       wr_q, wr_d;
  logic       rd_q, rd_d;

  wire byte_done = (cnt_q == sst_pkg::BYTE_BITS);
  wire addr_hit  = (sh_q[7:1] == addr_q);
  wire [7:0] ptr_next = ptr_q + 8'h01;

  always_comb begin
    st_d = st_q; cnt_d = cnt_q; sh_d = sh_q; idx_d = idx_q; ptr_d = ptr_q;
    waddr_d = waddr_q; wdat_d = wdat_q; rw_d = rw_q; first_d = first_q;
    pend_d = pend_q; ack_d = ack_q; oe_n_d = oe_n_q; wr_d = 1'b0; rd_d = 1'b0;
    if (!active || tmo_low || tmo_idle) begin
      st_d   = ST_IDLE;
      oe_n_d = 1'b1;
      pend_d = 1'b0;
    end else if (stop_ev) begin
      st_d   = ST_IDLE;
      oe_n_d = 1'b1;
      pend_d = 1'b0;
      // Index with no data: pointer only, and not in deepest sleep
      if (pend_q && !DEEPEST_LOW_POWER_FLAG) ptr_d = idx_q;
    end else if (start_ev) begin
      st_d   = ST_ADDR;
      cnt_d  = 4'h0;
      oe_n_d = 1'b1;
      pend_d = 1'b0;
      if (pend_q) ptr_d = idx_q;
    end else begin
      case (st_q)
        ST_ADDR, ST_RX: begin
          if (scl_rise && !byte_done) begin
            sh_d  = {sh_q[6:0], sda};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && byte_done && st_q == ST_ADDR) begin
            st_d   = addr_hit ? ST_AACK : ST_SKIP;
            oe_n_d = ~addr_hit;
            rw_d   = sh_q[0];
          end else if (scl_fall && byte_done) begin
            st_d   = ST_RACK;
            oe_n_d = 1'b0;
            first_d = 1'b0;
            if (first_q) begin
              idx_d  = sh_q;
              pend_d = 1'b1;
            end else begin
              waddr_d = pend_q ? idx_q : ptr_q;
              ptr_d   = (pend_q ? idx_q : ptr_q) + 8'h01;
              wdat_d  = sh_q;
              wr_d    = 1'b1;
              pend_d  = 1'b0;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall && rw_q) begin
            st_d   = ST_TX;
            sh_d   = REG_RDATA;
            oe_n_d = REG_RDATA[7];
            cnt_d  = 4'h1;
            rd_d   = 1'b1;
          end else if (scl_fall) begin
            st_d    = ST_RX;
            oe_n_d  = 1'b1;
            cnt_d   = 4'h0;
            first_d = 1'b1;
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            st_d   = ST_RX;
            oe_n_d = 1'b1;
            cnt_d  = 4'h0;
          end
        end
        ST_TX: begin
          if (scl_fall && byte_done) begin
            st_d   = ST_TACK;
            oe_n_d = 1'b1;
          end else if (scl_fall) begin
            oe_n_d = sh_q[6];
            sh_d   = {sh_q[6:0], 1'b0};
            cnt_d  = cnt_q + 4'h1;
          end
        end
        ST_TACK: begin
          if (scl_rise) begin
            ack_d = sda;
            // Advance only when the master asks for more
            if (!sda) ptr_d = ptr_next;
          end else if (scl_fall && !ack_q) begin
            st_d   = ST_TX;
            sh_d   = REG_RDATA;
            oe_n_d = REG_RDATA[7];
            cnt_d  = 4'h1;
            rd_d   = 1'b1;
          end else if (scl_fall) begin
            st_d = ST_SKIP;
          end
        end
        default: begin
          st_d = st_q;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      st_q <= ST_IDLE; cnt_q <= 4'h0; sh_q <= 8'h00; idx_q <= 8'h00;
      ptr_q <= sst_pkg::RST_PTR; waddr_q <= 8'h00; wdat_q <= 8'h00;
      rw_q <= 1'b0; first_q <= 1'b0; pend_q <= 1'b0; ack_q <= 1'b1;
      oe_n_q <= 1'b1; wr_q <= 1'b0; rd_q <= 1'b0;
    end else begin
      st_q <= st_d; cnt_q <= cnt_d; sh_q <= sh_d; idx_q <= idx_d;
      ptr_q <= ptr_d; waddr_q <= waddr_d; wdat_q <= wdat_d;
      rw_q <= rw_d; first_q <= first_d; pend_q <= pend_d; ack_q <= ack_d;
      oe_n_q <= oe_n_d; wr_q <= wr_d; rd_q <= rd_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign BUS.dev_data_o    = 1'b0;
  assign BUS.dev_data_oe_n = oe_n_q;
  assign PROTOCOL  = proto_q;
  assign BUS_ADDR  = addr_q;
  assign BUS_READY = ready_q;
  assign REG_PTR   = ptr_q;
  assign REG_WADDR = waddr_q;
  assign REG_WDATA = wdat_q;
  assign REG_WR    = wr_q;
  assign REG_RD    = rd_q;

endmodule : sst_slave

/* File: src/sst_master.sv */
`timescale 1ns/10ps
module sst_master (
  input  wire logic          CLK,
  input  wire logic          SYS_RST,
  sst_bus_if.host            BUS,
  input  wire logic          CMD_VALID,
  output logic               CMD_READY,
  input  sst_pkg::sst_cmd_t  CMD_KIND,
  input  wire logic [6:0]    CMD_DEV_ADDR,
  input  wire logic [7:0]    CMD_INDEX,
  input  wire logic [7:0]    CMD_LEN,
  input  wire logic [7:0]    WR_DATA,
  output logic               WR_TAKE,
  output logic      [7:0]    RD_DATA,
  output logic               RD_VALID,
  output logic               DONE,
  output logic               NACK_SEEN
);

  typedef enum logic [1:0] {MS_IDLE, MS_START, MS_BIT, MS_STOP} sst_mstate_t;
  typedef enum logic [2:0] {PH_ADDR_W, PH_INDEX, PH_WDATA, PH_ADDR_R, PH_RDATA} sst_phase_t;

  logic [1:0] line_lvl;
  sst_line_sync #(.W(2), .RST_VAL(sst_pkg::RST_LINES)) u_lines (
    .clk  (CLK),
    .rst  (SYS_RST),
    .raw  ({BUS.two_wire_clock_pin, BUS.two_wire_data_pin}),
    .lvl  (line_lvl),
    .rise (),
    .fall ()
  );

  // ****************************************
  // Quarter-period divider; this end makes the clock
  // ****************************************
  sst_mstate_t st_q;
  sst_phase_t  ph_q;
  sst_pkg::sst_cmd_t kind_q;
  logic [7:0]  div_q;
  logic [1:0]  qtr_q;
  logic [8:0]  out_q;
  logic [8:0]  rx_q;
  logic [3:0]  bcnt_q;
  logic [7:0]  left_q;
  logic [6:0]  dev_q;
  logic [7:0]  idx_q;
  logic        scl_oe_n_q;
  logic        sda_oe_n_q;
  logic [7:0]  rd_data_q;
  logic        rd_valid_q;
  logic        done_q;
  logic        nack_q;

  wire tick      = (div_q == sst_pkg::SCL_QTR_LAST);
  wire last_byte = (left_q == sst_pkg::LEN_ONE);
  wire is_data   = (ph_q == PH_WDATA) || (ph_q == PH_RDATA);
  wire ack_bad   = rx_q[0] & (ph_q != PH_RDATA);
  wire go_stop   = ack_bad || (is_data && last_byte) ||
                   (ph_q == PH_INDEX && kind_q == sst_pkg::CMD_SEND_BYTE);
  wire go_rstart = (ph_q == PH_INDEX) && (kind_q == sst_pkg::CMD_READ_BYTE);
  wire sst_phase_t next_ph =
      (ph_q == PH_ADDR_W) ? PH_INDEX :
      (ph_q == PH_INDEX)  ? (go_rstart ? PH_ADDR_R : PH_WDATA) :
      (ph_q == PH_ADDR_R) ? PH_RDATA : ph_q;
  wire load_now  = tick && (qtr_q == 2'h3) &&
                   ((st_q == MS_START) || (st_q == MS_BIT && bcnt_q == 4'h8 && !go_stop &&
                   !go_rstart));
  wire sst_phase_t load_ph = (st_q == MS_START) ? ph_q : next_ph;
  // Ninth bit released so the slave can acknowledge
  wire [8:0] load_val =
      (load_ph == PH_ADDR_W) ? {dev_q, 1'b0, 1'b1} :
      (load_ph == PH_INDEX)  ? {idx_q, 1'b1} :
      (load_ph == PH_WDATA)  ? {WR_DATA, 1'b1} :
      (load_ph == PH_ADDR_R) ? {dev_q, 1'b1, 1'b1} : 9'h1ff;
  // Acknowledge each read byte but the last
  wire bit_val = (ph_q == PH_RDATA && bcnt_q == 4'h8) ? last_byte : out_q[8];

  always_ff @(posedge CLK) begin
    if (SYS_RST || st_q == MS_IDLE || tick) div_q <= 8'h00;
    else div_q <= div_q + 8'h01;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      st_q <= MS_IDLE; ph_q <= PH_ADDR_W; kind_q <= sst_pkg::CMD_WRITE_BYTE;
      qtr_q <= 2'h0; out_q <= 9'h1ff; rx_q <= 9'h000; bcnt_q <= 4'h0;
      left_q <= sst_pkg::LEN_ONE; dev_q <= 7'h00; idx_q <= 8'h00;
      scl_oe_n_q <= 1'b1; sda_oe_n_q <= 1'b1;
      rd_data_q <= 8'h00; rd_valid_q <= 1'b0; done_q <= 1'b0; nack_q <= 1'b0;
    end else begin
      rd_valid_q <= 1'b0;
      done_q     <= 1'b0;
      if (load_now) begin
        out_q  <= load_val;
        bcnt_q <= 4'h0;
      end
      case (st_q)
        MS_IDLE: if (CMD_VALID) begin
          st_q   <= MS_START;
          qtr_q  <= 2'h0;
          kind_q <= CMD_KIND;
          dev_q  <= CMD_DEV_ADDR;
          idx_q  <= CMD_INDEX;
          left_q <= (CMD_LEN == 8'h00) ? sst_pkg::LEN_ONE : CMD_LEN;
          nack_q <= 1'b0;
          ph_q   <= (CMD_KIND == sst_pkg::CMD_RECV_BYTE) ? PH_ADDR_R : PH_ADDR_W;
        end
        MS_START: if (tick) begin
          qtr_q <= qtr_q + 2'h1;
          if (qtr_q == 2'h0) sda_oe_n_q <= 1'b1;
          if (qtr_q == 2'h1) scl_oe_n_q <= 1'b1;
          if (qtr_q == 2'h2) sda_oe_n_q <= 1'b0;
          if (qtr_q == 2'h3) begin
            scl_oe_n_q <= 1'b0;
            st_q       <= MS_BIT;
          end
        end
        MS_BIT: if (tick) begin
          qtr_q <= qtr_q + 2'h1;
          if (qtr_q == 2'h0) sda_oe_n_q <= bit_val;
          if (qtr_q == 2'h1) scl_oe_n_q <= 1'b1;
          if (qtr_q == 2'h2) rx_q <= {rx_q[7:0], line_lvl[0]};
          if (qtr_q == 2'h3) begin
            scl_oe_n_q <= 1'b0;
            if (bcnt_q != 4'h8) begin
              out_q  <= {out_q[7:0], 1'b1};
              bcnt_q <= bcnt_q + 4'h1;
            end else begin
              if (ph_q == PH_RDATA) begin
                rd_data_q  <= rx_q[8:1];
                rd_valid_q <= 1'b1;
              end
              if (is_data) left_q <= left_q - 8'h01;
              nack_q <= nack_q | ack_bad;
              ph_q   <= next_ph;
              st_q   <= go_stop ? MS_STOP : go_rstart ? MS_START : MS_BIT;
            end
          end
        end
        MS_STOP: if (tick) begin
          qtr_q <= qtr_q + 2'h1;
          if (qtr_q == 2'h0) sda_oe_n_q <= 1'b0;
          if (qtr_q == 2'h1) scl_oe_n_q <= 1'b1;
          if (qtr_q == 2'h2) sda_oe_n_q <= 1'b1;
          if (qtr_q == 2'h3) begin
            st_q   <= MS_IDLE;
            done_q <= 1'b1;
          end
        end
        default: st_q <= MS_IDLE;
      endcase
    end
  end

  assign WR_TAKE              = load_now && (load_ph == PH_WDATA);
  assign CMD_READY            = (st_q == MS_IDLE);
  assign BUS.host_clock_o     = 1'b0;
  assign BUS.host_clock_oe_n  = scl_oe_n_q;
  assign BUS.host_data_o      = 1'b0;
  assign BUS.host_data_oe_n   = sda_oe_n_q;
  // Board ties the select pin low in two-wire mode
  assign BUS.serial_select_n  = 1'b0;
  assign RD_DATA              = rd_data_q;
  assign RD_VALID             = rd_valid_q;
  assign DONE                 = done_q;
  assign NACK_SEEN            = nack_q;

endmodule : sst_master

/* File: bench/sst_link_properties.sv */
`timescale 1ns/10ps
module sst_link_properties (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic host_clock_oe_n,
  input wire logic dev_data_oe_n,
  input wire logic dev_data_o,
  input wire logic serial_select_n,
  input wire logic two_wire_clock_pin,
  input wire logic two_wire_data_pin
);
  // ****
  // Wire rules
  // ****
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  property p_no_stretch; !two_wire_clock_pin |-> !host_clock_oe_n; endproperty
  a_no_stretch: assert property (p_no_stretch)
    else $error("clock low without host");
  property p_clk_free; $rose(host_clock_oe_n) |-> two_wire_clock_pin; endproperty
  a_clk_free: assert property (p_clk_free)
    else $error("clock held after host release");
  property p_open_drain; dev_data_o == 1'b0; endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("device drives data high");
  property p_sel_gnd; serial_select_n == 1'b0; endproperty
  a_sel_gnd: assert property (p_sel_gnd)
    else $error("select pin not grounded");
  // Device moves data only deep in the clock low phase
  property p_move_low;
    $changed(dev_data_oe_n) |-> !two_wire_clock_pin && !$past(two_wire_clock_pin, 3);
  endproperty
  a_move_low: assert property (p_move_low)
    else $error("device data moved near clock high");
  property p_high_steady;
    two_wire_clock_pin && $past(two_wire_clock_pin) |-> $stable(dev_data_oe_n);
  endproperty
  a_high_steady: assert property (p_high_steady)
    else $error("device data moved while clock high");
  property p_ack_stands; $fell(dev_data_oe_n) |-> (!dev_data_oe_n) [*8]; endproperty
  a_ack_stands: assert property (p_ack_stands)
    else $error("ack pulse too short");
  property p_start_listen;
    $fell(two_wire_data_pin) && two_wire_clock_pin |=> dev_data_oe_n [*8];
  endproperty
  a_start_listen: assert property (p_start_listen)
    else $error("device drove data after start");
  property p_stop_release;
    $rose(two_wire_data_pin) && two_wire_clock_pin |=> dev_data_oe_n [*8];
  endproperty
  a_stop_release: assert property (p_stop_release)
    else $error("device drove data after stop");
  c_ack: cover property ($fell(dev_data_oe_n));
  c_start: cover property ($fell(two_wire_data_pin) && two_wire_clock_pin);
  c_stop: cover property ($rose(two_wire_data_pin) && two_wire_clock_pin);
endmodule : sst_link_properties

/* File: bench/tb.sv */
`timescale 1ns/10ps
module tb;
  // ****
  // Harness
  // ****
  logic              clk = 1'b0, rst = 1'b1, dlp = 1'b0, ten = 1'b0, cv = 1'b0;
  logic [2:0]        strap = 3'h0;
  sst_pkg::sst_cmd_t kind = sst_pkg::CMD_WRITE_BYTE;
  logic [6:0]        dev = 7'h28, baddr;
  logic [7:0]        idx = 8'h00, len = 8'h01, wdat = 8'h00, ptr, waddr, wdata, rdat;
  logic [7:0]        mem [256] = '{default: 8'h00};
  logic              wt, rv, done, nack, rdy, wr, rdp, crdy;
  sst_pkg::sst_proto_t proto;
  logic [15:0]       eq [$], rq [$];
  logic [7:0]        wq [$];
  int                n_fail = 0, total_checks = 0, n_rd = 0;
  always #5 clk = ~clk;
  sst_bus_if bus ();
  sst_slave #(.POWERUP_CYC(22'd200), .SCL_LOW_CYC(22'd2000), .BUS_IDLE_CYC(22'd1500))
    sst_slave_inst (.CLK(clk), .SYS_RST(rst), .BUS(bus), .COMM_SELECT_STRAP(strap),
    .DEEPEST_LOW_POWER_FLAG(dlp), .TIMEOUT_EN(ten), .PROTOCOL(proto), .BUS_ADDR(baddr),
    .BUS_READY(rdy), .REG_PTR(ptr), .REG_WADDR(waddr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RDATA(mem[ptr]), .REG_RD(rdp));
  sst_master sst_master_inst (.CLK(clk), .SYS_RST(rst), .BUS(bus), .CMD_VALID(cv),
    .CMD_READY(crdy), .CMD_KIND(kind), .CMD_DEV_ADDR(dev), .CMD_INDEX(idx), .CMD_LEN(len),
    .WR_DATA(wdat), .WR_TAKE(wt), .RD_DATA(rdat), .RD_VALID(rv), .DONE(done),
    .NACK_SEEN(nack));
  sst_link_properties sst_link_properties_inst (.CLK(clk), .SYS_RST(rst),
    .host_clock_oe_n(bus.host_clock_oe_n), .dev_data_oe_n(bus.dev_data_oe_n),
    .dev_data_o(bus.dev_data_o), .serial_select_n(bus.serial_select_n),
    .two_wire_clock_pin(bus.two_wire_clock_pin), .two_wire_data_pin(bus.two_wire_data_pin));
  task automatic chk(string s, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic print_verdict();
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task automatic cmd(sst_pkg::sst_cmd_t k, logic [6:0] a, logic [7:0] i, l, logic n);
    @(posedge clk);
    chk("cmd ready", 16'h1, 16'(crdy));
    kind <= k;
    dev <= a;
    idx <= i;
    len <= l;
    wdat <= wq[0];
    cv <= 1'b1;
    @(posedge clk);
    cv <= 1'b0;
    for (int c = 0; c < 20000 && done !== 1'b1; c++) @(posedge clk);
    chk("done", 16'h1, 16'(done));
    chk("nack", 16'(n), 16'(nack));
  endtask : cmd
  // ****
  // Monitor and tests
  // ****
  always @(posedge clk) begin
    if (wt) begin
      void'(wq.pop_front());
      wdat <= (wq.size() != 0) ? wq[0] : 8'h00;
    end
    if (rdp) n_rd++;
    if (wr) mem[waddr] <= wdata;
    if (wr) chk("write", eq.pop_front(), {waddr, wdata});
    if (rv) chk("read", rq.pop_front(), 16'(rdat));
  end
  initial begin
    #900us;
    n_fail++;
    print_verdict();
  end
  initial begin
    logic [7:0] d [3], v;
    void'($urandom(32'hfa97090d));
    for (int s = 0; s < 8; s++) begin
      rst <= 1'b1;
      strap <= 3'(s);
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (12) @(posedge clk);
      chk("proto", s > 2 ? 16'h3 : 16'(s), 16'(proto));
      chk("addr", s > 2 ? 16'(47 - s) : 16'h0, 16'(baddr));
      chk("ready", 16'h0, 16'(rdy));
    end
    strap <= 3'h0;
    ten <= 1'b1;
    repeat (12) @(posedge clk);
    chk("held", 16'h3, 16'(proto));
    for (int c = 0; c < 300 && rdy !== 1'b1; c++) @(posedge clk);
    chk("ready", 16'h1, 16'(rdy));
    foreach (d[i]) begin
      d[i] = 8'($urandom);
      wq.push_back(d[i]);
      eq.push_back({8'(255 + i), d[i]});
      rq.push_back(16'(d[i]));
    end
    cmd(sst_pkg::CMD_WRITE_BYTE, 7'h28, 8'hff, 8'h03, 1'b0);
    cmd(sst_pkg::CMD_READ_BYTE, 7'h28, 8'hff, 8'h03, 1'b0);
    v = 8'($urandom);
    wq.push_back(v);
    eq.push_back({8'h10, v});
    cmd(sst_pkg::CMD_WRITE_BYTE, 7'h28, 8'h10, 8'h01, 1'b0);
    dlp <= 1'b1;
    cmd(sst_pkg::CMD_SEND_BYTE, 7'h28, 8'h55, 8'h01, 1'b0);
    chk("ptr", 16'h11, 16'(ptr));
    dlp <= 1'b0;
    cmd(sst_pkg::CMD_SEND_BYTE, 7'h28, 8'h10, 8'h01, 1'b0);
    chk("ptr", 16'h10, 16'(ptr));
    // Long idle fires the idle timeout; the next start must still be seen
    repeat (1600) @(posedge clk);
    repeat (2) begin
      rq.push_back(16'(v));
      cmd(sst_pkg::CMD_RECV_BYTE, 7'h28, 8'h00, 8'h01, 1'b0);
    end
    cmd(sst_pkg::CMD_SEND_BYTE, 7'h2c, 8'h55, 8'h01, 1'b1);
    chk("left", 16'h0, 16'(eq.size() + rq.size()));
    chk("reg reads", 16'h5, 16'(n_rd));
    print_verdict();
  end
endmodule : tb
